// ---- inc/nio_params.svh ----
// Offsets, field positions, reset values and timing counts of the nibble port block.
`ifndef NIO_PARAMS_SVH
`define NIO_PARAMS_SVH
`define NIO_OFF_DIR      12'h000
`define NIO_OFF_PULL     12'h004
`define NIO_OFF_PULLDN   12'h008
`define NIO_OFF_ODRAIN   12'h00C
`define NIO_OFF_DOUT     12'h010
`define NIO_OFF_DIN      12'h014
`define NIO_OFF_ALT      12'h018
`define NIO_OFF_IRQEN    12'h01C
`define NIO_OFF_IRQSTAT  12'h020
`define NIO_CFG_W        12
`define NIO_CFG_RST      12'h000
`define NIO_IRQEN_MASTER 2
`define NIO_IRQ0_BIT     0
`define NIO_IRQ1_BIT     1
`define NIO_SAMPLE_DIV   305
`define NIO_DIV_W        9
`endif

// ---- inc/nio_pkg.sv ----
// Types shared by the nibble port block.
package nio_pkg;
	typedef logic [11:0] nio_cfg_t;
	typedef enum logic [1:0]
	{
		NIO_BUS_IDLE  = 2'b00,
		NIO_BUS_WRITE = 2'b01,
		NIO_BUS_READ  = 2'b10
	} nio_bus_e;
endpackage

// ---- hw/nio_ports.sv ----
// Three four-bit bidirectional ports with change interrupts and an AHB-Lite register slave.
//
// Notes on behaviour
// - Three independent four-bit ports, each pin able to drive and receive.
// - Software sets input or output direction separately for every port bit.
// - Each input bit selects a pull resistor or a high-impedance input.
// - Each output bit selects open-drain low-only drive or push-pull drive.
// - A level change on any pin of ports a or b raises request 0.
// - A level change on any pin of port c raises request 1.
// - Serial port and timer may take over pins as secondary functions.
// - Pin inputs are sampled on enable pulses from a time-base divider.
// - Requests are forwarded only with master enable and their own enable set.
`timescale 1ns/1ps
`include "nio_params.svh"

module nio_ports
#(
	parameter int SAMPLE_DIV = `NIO_SAMPLE_DIV
)
(
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Port pins, a in bits 3:0, b in 7:4, c in 11:8.
	input  wire logic [11:0] pin_in,
	output logic      [11:0] pin_out,
	output logic      [11:0] pin_oe,
	output logic      [11:0] pin_pull_en,
	output logic      [11:0] pin_pull_down,
	// Secondary functions.
	input  wire logic [11:0] alt_out,
	input  wire logic [11:0] alt_oe,
	output logic      [11:0] alt_in,
	// Interrupt requests to the processor.
	output logic             ext_irq0,
	output logic             ext_irq1
);

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	nio_pkg::nio_cfg_t dir_reg;
	nio_pkg::nio_cfg_t pull_reg;
	nio_pkg::nio_cfg_t pulldn_reg;
	nio_pkg::nio_cfg_t odrain_reg;
	nio_pkg::nio_cfg_t dout_reg;
	nio_pkg::nio_cfg_t alt_reg;
	logic [2:0]        irqen_reg;
	logic [1:0]        irqstat_reg;
	nio_pkg::nio_bus_e bus_reg;
	logic [11:0]       addr_reg;
	nio_pkg::nio_cfg_t samp_reg;
	logic [1:0]        chg;

	wire logic take = hsel && hready && htrans[1];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			bus_reg  <= nio_pkg::NIO_BUS_IDLE;
			addr_reg <= 12'h000;
		end
		else if (hready)
		begin
			addr_reg <= haddr;
			if (take)
				bus_reg <= hwrite ? nio_pkg::NIO_BUS_WRITE : nio_pkg::NIO_BUS_READ;
			else
				bus_reg <= nio_pkg::NIO_BUS_IDLE;
		end
	end

	wire logic wr = (bus_reg == nio_pkg::NIO_BUS_WRITE);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dir_reg    <= `NIO_CFG_RST;
			pull_reg   <= `NIO_CFG_RST;
			pulldn_reg <= `NIO_CFG_RST;
			odrain_reg <= `NIO_CFG_RST;
			dout_reg   <= `NIO_CFG_RST;
			alt_reg    <= `NIO_CFG_RST;
			irqen_reg  <= 3'h0;
		end
		else if (wr)
		begin
			case (addr_reg)
				`NIO_OFF_DIR:    dir_reg    <= hwdata[`NIO_CFG_W-1:0];
				`NIO_OFF_PULL:   pull_reg   <= hwdata[`NIO_CFG_W-1:0];
				`NIO_OFF_PULLDN: pulldn_reg <= hwdata[`NIO_CFG_W-1:0];
				`NIO_OFF_ODRAIN: odrain_reg <= hwdata[`NIO_CFG_W-1:0];
				`NIO_OFF_DOUT:   dout_reg   <= hwdata[`NIO_CFG_W-1:0];
				`NIO_OFF_ALT:    alt_reg    <= hwdata[`NIO_CFG_W-1:0];
				`NIO_OFF_IRQEN:  irqen_reg  <= hwdata[2:0];
				default:         dir_reg    <= dir_reg;
			endcase
		end
	end

	// Pending flags set on change and cleared by writing one; a set wins.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irqstat_reg <= 2'h0;
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (chg[i])
					irqstat_reg[i] <= 1'b1;
				else if (wr && addr_reg == `NIO_OFF_IRQSTAT && hwdata[i])
					irqstat_reg[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (take && !hwrite)
		begin
			case (haddr)
				`NIO_OFF_DIR:     hrdata <= {20'h00000, dir_reg};
				`NIO_OFF_PULL:    hrdata <= {20'h00000, pull_reg};
				`NIO_OFF_PULLDN:  hrdata <= {20'h00000, pulldn_reg};
				`NIO_OFF_ODRAIN:  hrdata <= {20'h00000, odrain_reg};
				`NIO_OFF_DOUT:    hrdata <= {20'h00000, dout_reg};
				`NIO_OFF_DIN:     hrdata <= {20'h00000, samp_reg};
				`NIO_OFF_ALT:     hrdata <= {20'h00000, alt_reg};
				`NIO_OFF_IRQEN:   hrdata <= {29'h0, irqen_reg};
				`NIO_OFF_IRQSTAT: hrdata <= {30'h0, irqstat_reg};
				default:          hrdata <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	function automatic logic [11:0] pick(input logic [11:0] sel, input logic [11:0] a,
	                                     input logic [11:0] b);
		pick = (sel & a) | (~sel & b);
	endfunction

	wire logic [11:0] drv_val = pick(alt_reg, alt_out, dout_reg);
	wire logic [11:0] drv_oe  = pick(alt_reg, alt_oe, dir_reg);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_out       <= 12'h000;
			pin_oe        <= 12'h000;
			pin_pull_en   <= 12'h000;
			pin_pull_down <= 12'h000;
		end
		else
		begin
			pin_out       <= drv_val & ~odrain_reg;
			pin_oe        <= drv_oe & (~odrain_reg | ~drv_val);
			pin_pull_en   <= ~drv_oe & pull_reg;
			pin_pull_down <= pulldn_reg;
		end
	end

	// ----------------------------------------------------------------
	// Sampling and change detection
	// ----------------------------------------------------------------
	logic [11:0]              sync1_reg;
	logic [11:0]              sync2_reg;
	logic [`NIO_DIV_W-1:0]    div_reg;
	logic                     tick_reg;
	logic                     primed_reg;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sync1_reg <= 12'h000;
			sync2_reg <= 12'h000;
		end
		else
		begin
			sync1_reg <= pin_in;
			sync2_reg <= sync1_reg;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			div_reg  <= '0;
			tick_reg <= 1'b0;
		end
		else if (div_reg == `NIO_DIV_W'(SAMPLE_DIV - 1))
		begin
			div_reg  <= '0;
			tick_reg <= 1'b1;
		end
		else
		begin
			div_reg  <= div_reg + `NIO_DIV_W'(1);
			tick_reg <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			samp_reg   <= 12'h000;
			primed_reg <= 1'b0;
		end
		else if (tick_reg)
		begin
			samp_reg   <= sync2_reg;
			primed_reg <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			alt_in <= 12'h000;
		else
			alt_in <= samp_reg;
	end

	wire logic [11:0] diff = (samp_reg ^ sync2_reg) & {12{tick_reg && primed_reg}};
	assign chg[`NIO_IRQ0_BIT] = |diff[7:0];
	assign chg[`NIO_IRQ1_BIT] = |diff[11:8];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ext_irq0 <= 1'b0;
			ext_irq1 <= 1'b0;
		end
		else
		begin
			ext_irq0 <= chg[`NIO_IRQ0_BIT] && irqen_reg[`NIO_IRQEN_MASTER]
				&& irqen_reg[`NIO_IRQ0_BIT];
			ext_irq1 <= chg[`NIO_IRQ1_BIT] && irqen_reg[`NIO_IRQEN_MASTER]
				&& irqen_reg[`NIO_IRQ1_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_irq0_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		ext_irq0 |-> $past(irqen_reg[2]) && $past(irqen_reg[0]))
		else $error("irq0 without enables");
	a_irq1_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		ext_irq1 |-> $past(irqen_reg[2]) && $past(irqen_reg[1]))
		else $error("irq1 without enables");
	a_irq0_cause: assert property (@(posedge hclk) disable iff (!hresetn)
		ext_irq0 |-> $past(tick_reg) && ($past(samp_reg[7:0]) != $past(sync2_reg[7:0])))
		else $error("irq0 without change");
	a_irq1_cause: assert property (@(posedge hclk) disable iff (!hresetn)
		ext_irq1 |-> $past(tick_reg) && ($past(samp_reg[11:8]) != $past(sync2_reg[11:8])))
		else $error("irq1 without change");
	a_irq_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
		ext_irq0 |=> !ext_irq0)
		else $error("irq0 longer than one cycle");
	a_tick_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
		tick_reg |=> !tick_reg [*2])
		else $error("sample ticks too close");
	a_odrain_high: assert property (@(posedge hclk) disable iff (!hresetn)
		(pin_oe & $past(odrain_reg) & $past(drv_val)) == 12'h000)
		else $error("open drain drove high");
	a_od_no_high: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(odrain_reg) == 12'hFFF |-> pin_out == 12'h000)
		else $error("open drain output high");
	a_input_float: assert property (@(posedge hclk) disable iff (!hresetn)
		($past(dir_reg) == 12'h000 && $past(alt_reg) == 12'h000) |-> pin_oe == 12'h000)
		else $error("input pin driven");
	a_pending_set: assert property (@(posedge hclk) disable iff (!hresetn)
		chg[0] |=> irqstat_reg[0])
		else $error("pending flag lost");

endmodule

// ---- dv/nio_board.sv ----
// Board model that settles each pin level from the device drivers, the pulls and the bench.
`timescale 1ns/1ps

module nio_board
(
	// Clock.
	input  wire logic        hclk,
	// Device side.
	input  wire logic [11:0] pin_out,
	input  wire logic [11:0] pin_oe,
	input  wire logic [11:0] pin_pull_en,
	input  wire logic [11:0] pin_pull_down,
	// Bench side.
	input  wire logic [11:0] ext_en,
	input  wire logic [11:0] ext_val,
	// Levels seen by the device.
	output logic      [11:0] pin_in
);
	// ----------------------------------------
	// Pin resolution
	// ----------------------------------------
	// A floating pin changes every cycle so that no stale level can pass for a real one.
	logic [11:0] flt_reg = 12'h000;

	always @(posedge hclk)
		flt_reg <= ~flt_reg;

	assign pin_in = (pin_oe & pin_out)
		| (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & pin_pull_en & ~pin_pull_down)
		| (~pin_oe & ~ext_en & ~pin_pull_en & flt_reg);
endmodule

// ---- dv/tb.sv ----
// Self-checking bench for the nibble port block.
`timescale 1ns/1ps
`include "nio_params.svh"

module tb;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [1:0]  htrans = 2'h0;
	logic [11:0] haddr = 12'h000, ext_en = 12'hFFF, ext_val = 12'h000;
	logic [11:0] alt_out = 12'h000, alt_oe = 12'h000;
	logic [31:0] hwdata = 32'h0, hrdata, rd, rnd = 32'hD351;
	logic        hreadyout, hresp, ext_irq0, ext_irq1;
	logic [11:0] pin_in, pin_out, pin_oe, pin_pull_en, pin_pull_down, alt_in;
	logic [11:0] offs [6] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h018};
	int          err_count = 0, checks = 0, c0, c1;

	always #50 hclk = ~hclk;

	nio_ports #(.SAMPLE_DIV(4)) i_nio_ports (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_en(pin_pull_en),
		.pin_pull_down(pin_pull_down), .alt_out(alt_out), .alt_oe(alt_oe),
		.alt_in(alt_in), .ext_irq0(ext_irq0), .ext_irq1(ext_irq1));

	nio_board i_nio_board (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pull_en(pin_pull_en), .pin_pull_down(pin_pull_down), .ext_en(ext_en),
		.ext_val(ext_val), .pin_in(pin_in));

	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task test_done;
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			$display("unexpected t=%0t got=%h exp=%h", $time, g, e);
			err_count++;
		end
	endtask

	// ----------------------------------------
	// Bus transfers
	// ----------------------------------------
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 50);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 100);
		rd = hrdata;
		if (n >= 50)
		begin
			err_count++;
			test_done();
		end
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task rdc(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
		chk(hresp, 32'h0);
	endtask

	task watch;
		c0 = 0;
		c1 = 0;
		repeat (40)
		begin
			@(posedge hclk);
			#1;
			c0 += (ext_irq0 === 1'b1);
			c1 += (ext_irq1 === 1'b1);
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		chk(pin_oe, 32'h0);
		rdc(`NIO_OFF_DIR, 32'h0);
		for (int k = 0; k < 6; k++)
		begin
			rnd = lfsr(rnd);
			wr(offs[k], rnd);
			rdc(offs[k], rnd & 32'hFFF);
		end
		rdc(12'h03C, 32'h0);
		rnd = lfsr(rnd);
		wr(`NIO_OFF_ALT, 32'h0);
		wr(`NIO_OFF_ODRAIN, 32'h0);
		wr(`NIO_OFF_DOUT, rnd);
		wr(`NIO_OFF_DIR, 32'hFFF);
		repeat (2) @(posedge hclk);
		chk(pin_oe, 32'hFFF);
		chk(pin_out, rnd & 32'hFFF);
		repeat (30) @(posedge hclk);
		rdc(`NIO_OFF_DIN, rnd & 32'hFFF);
		wr(`NIO_OFF_ODRAIN, 32'hFFF);
		repeat (2) @(posedge hclk);
		chk(pin_oe, ~rnd & 32'hFFF);
		wr(`NIO_OFF_ODRAIN, 32'h0);
		wr(`NIO_OFF_DIR, 32'h0);
		ext_en <= 12'h000;
		wr(`NIO_OFF_PULL, 32'hFFF);
		wr(`NIO_OFF_PULLDN, rnd);
		repeat (30) @(posedge hclk);
		chk(pin_pull_en, 32'hFFF);
		rdc(`NIO_OFF_DIN, ~rnd & 32'hFFF);
		chk(alt_in, ~rnd & 32'hFFF);
		wr(`NIO_OFF_PULL, 32'h0);
		repeat (2) @(posedge hclk);
		chk(pin_pull_en, 32'h0);
		ext_en <= 12'hFFF;
		rnd = lfsr(rnd);
		alt_out <= rnd[11:0];
		alt_oe <= 12'hFFF;
		wr(`NIO_OFF_ALT, 32'hFFF);
		repeat (3) @(posedge hclk);
		chk(pin_oe, 32'hFFF);
		chk(pin_out, rnd & 32'hFFF);
		wr(`NIO_OFF_ALT, 32'h0);
		alt_oe <= 12'h000;
		wr(`NIO_OFF_IRQEN, 32'h7);
		rdc(`NIO_OFF_IRQEN, 32'h7);
		repeat (30) @(posedge hclk);
		wr(`NIO_OFF_IRQSTAT, 32'h3);
		for (int i = 0; i < 12; i++)
		begin
			ext_val <= ext_val ^ (12'h001 << i);
			watch();
			chk(c0, i < 8);
			chk(c1, i >= 8);
			rdc(`NIO_OFF_IRQSTAT, (i < 8) ? 32'h1 : 32'h2);
			wr(`NIO_OFF_IRQSTAT, 32'h3);
		end
		for (int e = 3; e < 7; e++)
		begin
			wr(`NIO_OFF_IRQEN, e);
			ext_val <= ext_val ^ 12'h101;
			watch();
			chk(c0, e == 5);
			chk(c1, e == 6);
			rdc(`NIO_OFF_IRQSTAT, 32'h3);
			wr(`NIO_OFF_IRQSTAT, 32'h3);
		end
		test_done();
	end
endmodule
